// ### verilog/flag_pop_pkg.sv
// Constants for the flag pop execution block.
// Assumes a 64-bit flags register image and a host pipeline that supplies the popped word.
package flag_pop_pkg;
   localparam logic [7:0] OPC_POP_FLAGS = 8'h9D;
   localparam logic [1:0] SIZE_16 = 2'h0;
   localparam logic [1:0] SIZE_32 = 2'h1;
   localparam logic [1:0] SIZE_64 = 2'h2;
   localparam int CF_POS = 0;
   localparam int RSV1_POS = 1;
   localparam int RSV3_POS = 3;
   localparam int RSV5_POS = 5;
   localparam int IF_POS = 9;
   localparam int IO_PRIVILEGE_FIELD_LO = 12;
   localparam int RSV15_POS = 15;
   localparam int RF_POS = 16;
   localparam int VM_POS = 17;
   localparam int VIF_POS = 19;
   localparam int VIP_POS = 20;
   localparam int ID_POS = 21;
   localparam logic [63:0] RSV_MASK = 64'hFFFF_FFFF_FFC0_802A;
   localparam logic [63:0] RSV_VALUE = 64'h0000_0000_0000_0002;
   localparam logic [63:0] FLAGS_RESET = 64'h0000_0000_0000_0002;
   localparam logic [63:0] IF_MASK = 64'h0000_0000_0000_0200;
   localparam logic [63:0] IO_PRIVILEGE_FIELD_MASK = 64'h0000_0000_0000_3000;
   localparam logic [63:0] RF_MASK = 64'h0000_0000_0001_0000;
   localparam logic [63:0] VM_MASK = 64'h0000_0000_0002_0000;
   localparam logic [63:0] VIF_MASK = 64'h0000_0000_0008_0000;
   localparam logic [63:0] VIP_MASK = 64'h0000_0000_0010_0000;
   localparam logic [63:0] LOW16_MASK = 64'h0000_0000_0000_FFFF;
   localparam logic [63:0] LOW32_MASK = 64'h0000_0000_FFFF_FFFF;
   localparam logic [1:0] PL_MAX = 2'h3;
endpackage : flag_pop_pkg

// ### verilog/flag_pop_execution.sv
// Flag pop execution: decodes the flag pop opcode and merges the popped word into the flags.
// Assumes mode inputs hold from START to DONE and the popped word stands one cycle after START.
`timescale 1ns/10ps
module flag_pop_execution
(
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic START,
   input wire logic [7:0] OPCODE,
   input wire logic [1:0] OPERAND_SIZE,
   input wire logic WIDE_OPERAND_PREFIX,
   input wire logic LONG_MODE,
   input wire logic PROTECTED_MODE,
   input wire logic VIRTUAL_8086_MODE,
   input wire logic [1:0] PRIVILEGE_LEVEL,
   input wire logic [63:0] STACK_DATA,
   output logic [63:0] EXTENDED_FLAGS_REGISTER,
   output logic [3:0] POP_BYTES,
   output logic DONE,
   output logic GENERAL_PROTECTION_FAULT,
   output logic UNDEFINED_OPCODE
);
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'h1,
      ST_EXEC = 3'h2,
      ST_DONE = 3'h4
   } state_t;

   state_t state_ff;
   state_t nxt_state;
   logic [63:0] flags_ff;
   logic [63:0] nxt_flags;
   logic [3:0] bytes_ff;
   logic [3:0] nxt_bytes;
   logic done_ff;
   logic nxt_done;
   logic gp_ff;
   logic nxt_gp;
   logic ud_ff;
   logic nxt_ud;
   logic [1:0] io_privilege_field;
   logic vm_mode;
   logic is_pop;
   logic quad;
   logic illegal;
   logic fault_cond;
   logic pop_ok;
   logic [63:0] load_mask;
   logic [63:0] clear_mask;
   logic [63:0] popped;

   // Shared decode of the privilege field, used by both the merge and the checks.
   function automatic logic [1:0] io_privilege_field_of(input logic [63:0] f);
      io_privilege_field_of = f[flag_pop_pkg::IO_PRIVILEGE_FIELD_LO +: 2];
   endfunction : io_privilege_field_of

   assign io_privilege_field = io_privilege_field_of(flags_ff);
   // The 8086 state comes from the host, because no flag pop may ever set that flag itself.
   assign vm_mode = VIRTUAL_8086_MODE;
   assign fault_cond = vm_mode && (io_privilege_field != flag_pop_pkg::PL_MAX);
   assign pop_ok = (state_ff == ST_EXEC) && !illegal && !fault_cond;
   assign is_pop = (OPCODE == flag_pop_pkg::OPC_POP_FLAGS);
   assign quad = LONG_MODE && WIDE_OPERAND_PREFIX;
   // In long mode without the wide prefix the 32-bit form is rejected; outside long mode
   // the prefix is meaningless and the legacy size rules apply.
   assign illegal = (LONG_MODE && !WIDE_OPERAND_PREFIX
                     && OPERAND_SIZE == flag_pop_pkg::SIZE_32)
                    || (!LONG_MODE && OPERAND_SIZE == flag_pop_pkg::SIZE_64);

   always_comb
   begin
      popped = STACK_DATA;
      load_mask = ~flag_pop_pkg::RSV_MASK;
      clear_mask = 64'h0;
      if (quad)
      begin
         popped = STACK_DATA & flag_pop_pkg::LOW32_MASK;
      end
      else if (OPERAND_SIZE == flag_pop_pkg::SIZE_16)
      begin
         load_mask = load_mask & flag_pop_pkg::LOW16_MASK;
      end
      else
      begin
         load_mask = load_mask & flag_pop_pkg::LOW32_MASK;
      end
      // Resume, 8086 and virtual flags never load from the stack.
      load_mask = load_mask & ~(flag_pop_pkg::RF_MASK | flag_pop_pkg::VM_MASK
                                | flag_pop_pkg::VIF_MASK | flag_pop_pkg::VIP_MASK);
      if (vm_mode)
      begin
         load_mask = load_mask & ~flag_pop_pkg::IO_PRIVILEGE_FIELD_MASK;
      end
      else if (PROTECTED_MODE && PRIVILEGE_LEVEL != 2'h0)
      begin
         load_mask = load_mask & ~flag_pop_pkg::IO_PRIVILEGE_FIELD_MASK;
         if (PRIVILEGE_LEVEL > io_privilege_field)
         begin
            load_mask = load_mask & ~flag_pop_pkg::IF_MASK;
         end
         else
         begin
            clear_mask = flag_pop_pkg::VIF_MASK | flag_pop_pkg::VIP_MASK;
         end
      end
   end

   always_comb
   begin
      nxt_state = state_ff;
      nxt_flags = flags_ff;
      nxt_bytes = bytes_ff;
      nxt_done = 1'b0;
      nxt_gp = 1'b0;
      nxt_ud = 1'b0;
      unique case (state_ff)
         ST_IDLE:
         begin
            if (START && is_pop)
            begin
               nxt_state = ST_EXEC;
            end
         end
         ST_EXEC:
         begin
            nxt_state = ST_DONE;
            nxt_done = 1'b1;
            nxt_flags = flags_ff & ~flag_pop_pkg::RF_MASK;
            if (illegal)
            begin
               nxt_ud = 1'b1;
            end
            else if (fault_cond)
            begin
               nxt_gp = 1'b1;
            end
            else
            begin
               nxt_flags = (((flags_ff & ~flag_pop_pkg::RF_MASK) & ~load_mask)
                            | (popped & load_mask)) & ~clear_mask;
               nxt_flags = (nxt_flags & ~flag_pop_pkg::RSV_MASK)
                           | flag_pop_pkg::RSV_VALUE;
               nxt_bytes = quad ? 4'h8 :
                           (OPERAND_SIZE == flag_pop_pkg::SIZE_16) ? 4'h2 : 4'h4;
            end
         end
         ST_DONE:
         begin
            nxt_state = ST_IDLE;
         end
         default:
         begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLOCK)
   begin
      if (!RST_N)
      begin
         state_ff <= ST_IDLE;
         flags_ff <= flag_pop_pkg::FLAGS_RESET;
         bytes_ff <= 4'h0;
         done_ff <= 1'b0;
         gp_ff <= 1'b0;
         ud_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         flags_ff <= nxt_flags;
         bytes_ff <= nxt_bytes;
         done_ff <= nxt_done;
         gp_ff <= nxt_gp;
         ud_ff <= nxt_ud;
      end
   end

   assign EXTENDED_FLAGS_REGISTER = flags_ff;
   assign POP_BYTES = bytes_ff;
   assign DONE = done_ff;
   assign GENERAL_PROTECTION_FAULT = gp_ff;
   assign UNDEFINED_OPCODE = ud_ff;

   resume_zero_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
      DONE |-> !EXTENDED_FLAGS_REGISTER[flag_pop_pkg::RF_POS])
      else $error("Resume flag set after pop.");

   reserved_fixed_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
      DONE |-> ((EXTENDED_FLAGS_REGISTER & flag_pop_pkg::RSV_MASK) == flag_pop_pkg::RSV_VALUE))
      else $error("Reserved flag bits changed.");

   vm_keep_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
      state_ff == ST_EXEC |=> EXTENDED_FLAGS_REGISTER[flag_pop_pkg::VM_POS]
                              == $past(flags_ff[flag_pop_pkg::VM_POS]))
      else $error("8086 flag changed by pop.");

   gp_fault_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (state_ff == ST_EXEC && !illegal && vm_mode && io_privilege_field != 2'h3) |=> GENERAL_PROTECTION_FAULT
      && $stable(EXTENDED_FLAGS_REGISTER[15:0]))
      else $error("Missing fault in 8086 mode.");

   no_gp_pm_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (state_ff == ST_EXEC && !vm_mode) |=> !GENERAL_PROTECTION_FAULT)
      else $error("Fault outside 8086 mode.");

   high_zero_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
      DONE |-> EXTENDED_FLAGS_REGISTER[63:32] == 32'h0)
      else $error("Upper flag bits not zero.");

   word_keep_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (state_ff == ST_EXEC && !quad && OPERAND_SIZE == flag_pop_pkg::SIZE_16)
      |=> EXTENDED_FLAGS_REGISTER[31:17] == $past(flags_ff[31:17]))
      else $error("Word pop touched upper flags.");

   if_guard_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (state_ff == ST_EXEC && PROTECTED_MODE && !vm_mode && PRIVILEGE_LEVEL > io_privilege_field)
      |=> $stable(EXTENDED_FLAGS_REGISTER[flag_pop_pkg::IF_POS]))
      else $error("Interrupt enable changed without privilege.");

   size32_ud_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (state_ff == ST_EXEC && LONG_MODE && !WIDE_OPERAND_PREFIX
       && OPERAND_SIZE == flag_pop_pkg::SIZE_32) |=> UNDEFINED_OPCODE)
      else $error("32-bit pop accepted in long mode.");

   vif_clear_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (state_ff == ST_EXEC && !illegal && PROTECTED_MODE && !vm_mode
       && PRIVILEGE_LEVEL != 2'h0 && PRIVILEGE_LEVEL <= io_privilege_field)
      |=> !EXTENDED_FLAGS_REGISTER[flag_pop_pkg::VIF_POS])
      else $error("Virtual interrupt flag not cleared.");

   vm_io_keep_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (pop_ok && vm_mode)
      |=> $stable(EXTENDED_FLAGS_REGISTER[flag_pop_pkg::IO_PRIVILEGE_FIELD_LO +: 2])
          && !GENERAL_PROTECTION_FAULT)
      else $error("Io field changed by a pop in 8086 mode.");

   vm_virt_keep_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (pop_ok && vm_mode)
      |=> $stable(EXTENDED_FLAGS_REGISTER[flag_pop_pkg::VIF_POS])
          && $stable(EXTENDED_FLAGS_REGISTER[flag_pop_pkg::VIP_POS]))
      else $error("Virtual flags changed by a pop in 8086 mode.");

   io_keep_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (pop_ok && !vm_mode && PROTECTED_MODE && PRIVILEGE_LEVEL != 2'h0)
      |=> $stable(EXTENDED_FLAGS_REGISTER[flag_pop_pkg::IO_PRIVILEGE_FIELD_LO +: 2]))
      else $error("Io field changed above level 0.");

   if_load_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (pop_ok && !vm_mode && (!PROTECTED_MODE || PRIVILEGE_LEVEL <= io_privilege_field))
      |=> EXTENDED_FLAGS_REGISTER[flag_pop_pkg::IF_POS]
          == $past(STACK_DATA[flag_pop_pkg::IF_POS]))
      else $error("Interrupt enable not loaded with privilege.");

   level0_virt_keep_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (state_ff == ST_EXEC && !vm_mode && (!PROTECTED_MODE || PRIVILEGE_LEVEL == 2'h0))
      |=> $stable(EXTENDED_FLAGS_REGISTER[flag_pop_pkg::VIF_POS])
          && $stable(EXTENDED_FLAGS_REGISTER[flag_pop_pkg::VIP_POS]))
      else $error("Virtual flags changed at level 0.");

   word_bytes_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (pop_ok && !quad && OPERAND_SIZE == flag_pop_pkg::SIZE_16) |=> POP_BYTES == 4'h2)
      else $error("Word pop did not take two bytes.");

   dword_bytes_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (pop_ok && !quad && OPERAND_SIZE == flag_pop_pkg::SIZE_32) |=> POP_BYTES == 4'h4)
      else $error("Doubleword pop did not take four bytes.");

   quad_bytes_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (pop_ok && quad) |=> POP_BYTES == 4'h8)
      else $error("Quadword pop did not take eight bytes.");

   legacy_ud_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (state_ff == ST_EXEC && !LONG_MODE && OPERAND_SIZE == flag_pop_pkg::SIZE_64)
      |=> UNDEFINED_OPCODE)
      else $error("Quadword pop accepted outside long mode.");

   other_opc_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (state_ff == ST_IDLE && START && !is_pop) |=> state_ff == ST_IDLE)
      else $error("Other opcode started a pop.");

   fault_keep_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (state_ff == ST_EXEC && !illegal && fault_cond)
      |=> $stable(POP_BYTES) && !UNDEFINED_OPCODE)
      else $error("Faulting pop changed the byte count.");

   ud_keep_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (state_ff == ST_EXEC && illegal)
      |=> $stable(EXTENDED_FLAGS_REGISTER[15:0]) && !GENERAL_PROTECTION_FAULT)
      else $error("Rejected pop changed the flags.");

   word_pop_c: cover property (@(posedge CLOCK) disable iff (!RST_N) DONE && POP_BYTES == 4'h2);
   quad_pop_c: cover property (@(posedge CLOCK) disable iff (!RST_N) DONE && POP_BYTES == 4'h8);
   gp_seen_c: cover property (@(posedge CLOCK) disable iff (!RST_N) GENERAL_PROTECTION_FAULT);
   ud_seen_c: cover property (@(posedge CLOCK) disable iff (!RST_N) UNDEFINED_OPCODE);
   vm_pop_c: cover property (@(posedge CLOCK) disable iff (!RST_N)
      DONE && VIRTUAL_8086_MODE && !GENERAL_PROTECTION_FAULT);
endmodule : flag_pop_execution

// ### dv/stack_model.sv
// Stack memory model that hands the popped word to the flag pop block.
// Assumes the word is wanted only in the cycle after START; other cycles show a changing pattern.
`timescale 1ns/10ps
module stack_model
(
   input wire logic CLOCK,
   input wire logic START,
   input wire logic [63:0] WORD,
   output logic [63:0] STACK_DATA
);
   logic exec_ff = 1'b0;
   logic nxt_exec;
   logic [63:0] junk_ff = 64'hA5A5_5A5A_C3C3_3C3C;
   logic [63:0] nxt_junk;
   // The pattern flips every cycle so that a sample outside the read cycle shows up at once.
   always_comb
   begin
      nxt_exec = START;
      nxt_junk = ~junk_ff;
   end
   always_ff @(posedge CLOCK)
   begin
      exec_ff <= nxt_exec;
      junk_ff <= nxt_junk;
   end
   assign STACK_DATA = exec_ff ? WORD : junk_ff;
endmodule : stack_model

// ### dv/flag_pop_execution_tb.sv
// Self-checking bench for the flag pop block, with the stack model on its data side.
// Assumes DONE pulses for one cycle, starting at the edge after the one that takes START.
`timescale 1ns/10ps
module flag_pop_execution_tb;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic start = 1'b0;
   logic [7:0] opcode = 8'h00;
   logic [1:0] operand_size = 2'h0;
   logic wide = 1'b0;
   logic long_mode = 1'b0;
   logic prot_mode = 1'b0;
   logic [1:0] priv = 2'h0;
   logic vm = 1'b0;
   logic [63:0] word = 64'h0;
   logic [63:0] stack_data;
   logic [63:0] flags;
   logic [3:0] pop_bytes;
   logic done;
   logic gp_fault;
   logic undef;
   logic [63:0] exp_flags = flag_pop_pkg::FLAGS_RESET;
   logic [3:0] exp_bytes = 4'h0;
   int errors = 0;
   int checks_done = 0;
   int test_no = 0;
   always #2.5 clock = ~clock;
   stack_model stack_model_i (.CLOCK(clock), .START(start), .WORD(word), .STACK_DATA(stack_data));
   flag_pop_execution flag_pop_execution_i (.CLOCK(clock), .RST_N(rst_n), .START(start),
      .OPCODE(opcode), .OPERAND_SIZE(operand_size), .WIDE_OPERAND_PREFIX(wide),
      .LONG_MODE(long_mode), .PROTECTED_MODE(prot_mode), .VIRTUAL_8086_MODE(vm),
      .PRIVILEGE_LEVEL(priv),
      .STACK_DATA(stack_data), .EXTENDED_FLAGS_REGISTER(flags), .POP_BYTES(pop_bytes),
      .DONE(done), .GENERAL_PROTECTION_FAULT(gp_fault), .UNDEFINED_OPCODE(undef));
   task automatic check(input logic [63:0] got, input logic [63:0] want);
      checks_done++;
      if (got !== want)
      begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, got, want);
      end
   endtask : check
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test
   // One pop request; the expected image is worked out from the mode inputs and the old image.
   task automatic pop(input logic [7:0] opc, input logic [1:0] sz, input logic w,
      input logic lm, input logic pm, input logic [1:0] pl, input logic [63:0] d);
      logic [63:0] m;
      logic [1:0] io_privilege_field;
      logic ud;
      logic go;
      logic [3:0] nb;
      logic gp;
      io_privilege_field = exp_flags[13:12];
      go = (opc === flag_pop_pkg::OPC_POP_FLAGS);
      ud = lm ? (!w && sz == flag_pop_pkg::SIZE_32) : (sz == flag_pop_pkg::SIZE_64);
      nb = (lm && w) ? 4'h8 : ((sz == flag_pop_pkg::SIZE_32) ? 4'h4 : 4'h2);
      m = ~flag_pop_pkg::RSV_MASK & ~(flag_pop_pkg::RF_MASK | flag_pop_pkg::VM_MASK);
      m = m & ~(flag_pop_pkg::VIF_MASK | flag_pop_pkg::VIP_MASK);
      m = m & (((lm && w) || sz == flag_pop_pkg::SIZE_32) ? flag_pop_pkg::LOW32_MASK
         : flag_pop_pkg::LOW16_MASK);
      if (vm || (pm && pl != 2'h0))
         m = m & ~flag_pop_pkg::IO_PRIVILEGE_FIELD_MASK;
      if (!vm && pm && pl > io_privilege_field)
         m = m & ~flag_pop_pkg::IF_MASK;
      gp = go && !ud && vm && (io_privilege_field != flag_pop_pkg::PL_MAX);
      opcode = opc;
      operand_size = sz;
      wide = w;
      long_mode = lm;
      prot_mode = pm;
      priv = pl;
      word = d;
      start = 1'b1;
      @(negedge clock);
      start = 1'b0;
      @(negedge clock);
      if (go)
      begin
         if (!ud && !gp)
         begin
            exp_flags = (exp_flags & ~m) | (d & m);
            exp_bytes = nb;
         end
         exp_flags = exp_flags & ~flag_pop_pkg::RF_MASK;
      end
      check({63'h0, done}, {63'h0, go});
      check({63'h0, gp_fault}, {63'h0, gp});
      check({63'h0, undef}, {63'h0, go && ud});
      check(flags, exp_flags);
      check({60'h0, pop_bytes}, {60'h0, exp_bytes});
      @(negedge clock);
      check({63'h0, done}, 64'h0);
      test_no++;
      $display("Test %0d finished", test_no);
   endtask : pop
   initial
   begin
      #(5.0 * 2000);
      errors++;
      end_of_test();
   end
   initial
   begin
      repeat (3) @(negedge clock);
      rst_n = 1'b1;
      check(flags, flag_pop_pkg::FLAGS_RESET);
      check({60'h0, pop_bytes}, 64'h0);
      pop(8'h9D, flag_pop_pkg::SIZE_16, 1'b0, 1'b0, 1'b0, 2'h0, '1);
      pop(8'h9D, flag_pop_pkg::SIZE_32, 1'b0, 1'b0, 1'b1, 2'h0, '1);
      pop(8'h9D, flag_pop_pkg::SIZE_16, 1'b0, 1'b0, 1'b1, 2'h0, 64'h0);
      pop(8'h9D, flag_pop_pkg::SIZE_32, 1'b1, 1'b1, 1'b1, 2'h0, '1);
      pop(8'h9D, flag_pop_pkg::SIZE_32, 1'b0, 1'b1, 1'b1, 2'h0, 64'h0);
      pop(8'h9D, flag_pop_pkg::SIZE_64, 1'b0, 1'b0, 1'b1, 2'h0, 64'h0);
      pop(8'h9D, flag_pop_pkg::SIZE_16, 1'b0, 1'b1, 1'b1, 2'h0, 64'h0000_0000_0000_35D5);
      pop(8'h9D, flag_pop_pkg::SIZE_32, 1'b0, 1'b0, 1'b1, 2'h1, 64'h0);
      pop(8'h9D, flag_pop_pkg::SIZE_32, 1'b0, 1'b0, 1'b1, 2'h3, '1);
      pop(8'h9D, flag_pop_pkg::SIZE_32, 1'b0, 1'b0, 1'b1, 2'h0, 64'h0);
      pop(8'h9D, flag_pop_pkg::SIZE_16, 1'b0, 1'b0, 1'b1, 2'h2, '1);
      vm = 1'b1;
      pop(8'h9D, flag_pop_pkg::SIZE_16, 1'b0, 1'b0, 1'b1, 2'h3, '1);
      vm = 1'b0;
      pop(8'h9D, flag_pop_pkg::SIZE_16, 1'b0, 1'b0, 1'b0, 2'h0, 64'h3200);
      vm = 1'b1;
      pop(8'h9D, flag_pop_pkg::SIZE_32, 1'b0, 1'b0, 1'b1, 2'h3, 64'h0);
      vm = 1'b0;
      pop(8'h90, flag_pop_pkg::SIZE_32, 1'b0, 1'b0, 1'b0, 2'h0, '1);
      end_of_test();
   end
endmodule : flag_pop_execution_tb
